// ===== pcs_card_model.sv
/*
 * Behavioural model of an inserted 16-bit card facing the socket block.
 * Assumes the bench sets the card's pin levels and that the ack line has a pull-up.
 */
`timescale 1ns/100ps
`default_nettype none
module pcs_card_model
    import pcs_pkg::*;
(
    // Clock.
    input  wire logic       clk,
    // Bench controls of the card.
    input  wire logic       bat_a,
    input  wire logic       bat_b,
    input  wire logic [1:0] ins,
    input  wire logic       answer,
    input  wire logic       dreq,
    // Controller strobes.
    input  wire logic       io_read_strobe_n,
    input  wire logic       dma_acknowledge_n,
    // Card pins.
    output logic            battery_detect_a,
    output logic            battery_detect_b,
    output logic            card_present_1,
    output logic            card_present_2,
    output var logic        io_read_ack_n
);
    assign battery_detect_a = bat_a;
    assign battery_detect_b = bat_b;
    // An absent card drives each detect pin high; a set ins bit drives its pin low.
    assign card_present_1 = ~ins[0];
    assign card_present_2 = ~ins[1];
    initial io_read_ack_n = 1'b1;
    // Outside a read the line is driven high unless dreq pulls it low.
    always @(posedge clk) begin
        io_read_ack_n <= ~((answer & ~io_read_strobe_n & dma_acknowledge_n) | dreq);
    end
endmodule : pcs_card_model
`default_nettype wire

// ===== pcs_defs.svh
/*
 * Constants of the socket status and strobe block: timing, pin positions, widths.
 * Assumes the block clock runs at the period given here.
 */
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
`define PCS_CLK_NS       4
`define PCS_SETUP_NS     30
`define PCS_STROBE_NS    120
`define PCS_HOLD_NS      30
`define PCS_CYC(ns)      (((ns) + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_SETUP_CYC    `PCS_CYC(`PCS_SETUP_NS)
`define PCS_STROBE_CYC   `PCS_CYC(`PCS_STROBE_NS)
`define PCS_HOLD_CYC     `PCS_CYC(`PCS_HOLD_NS)
`define PCS_CNT_W        6
`define PCS_IN_W         6
`define PCS_IN_BAT_A     0
`define PCS_IN_BAT_B     1
`define PCS_IN_PRES1     2
`define PCS_IN_PRES2     3
`define PCS_IN_RDACK     4
`define PCS_IN_AUDIO     5
`define PCS_IN_RESET     6'h3f
`define PCS_STATUS_MASK  6'h0f
`define PCS_BUF_FULL     2'h2
`endif

// ===== pcs_pkg.sv
/*
 * Types of the socket status and strobe block.
 * Assumes nothing beyond a SystemVerilog tool.
 */
`default_nettype none
package pcs_pkg;
    typedef enum logic [1:0] {PCS_IO_READ, PCS_IO_WRITE, PCS_DMA_TO_HOST, PCS_DMA_TO_CARD} pcs_kind_t;
    typedef enum logic [1:0] {PCS_BAT_GOOD, PCS_BAT_WEAK, PCS_BAT_DEAD} pcs_battery_t;
    typedef enum logic [1:0] {PCS_IDLE, PCS_SETUP, PCS_STROBE, PCS_HOLD} pcs_state_t;
    typedef struct packed {
        pcs_kind_t kind;
        logic      odd;
        logic      wide;
        logic      last;
    } pcs_cmd_t;
endpackage : pcs_pkg
`default_nettype wire

// ===== pcs_socket_status.sv
/*
 * Socket status decode, speaker mix, byte selects and I/O or DMA strobes.
 * Assumes card pins arrive asynchronously and host requests on CLK.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pcs_defs.svh"
// Operation
// - Battery: both high good, B low with A high weak, A low dead.
// - In I/O mode with ring disabled, a falling status-change input is reported as an event.
// - With ring enabled, a falling ring-indicate input is reported as a ring; the block does so only in I/O mode.
// - Speaker accepted only in I/O mode, mixed with other socket onto audio output.
// - With DMA enabled and not on acknowledge, battery-detect B low is the DMA request.
// - Card inserted when both card-present inputs are low; their state is reported.
// - Even byte select for even bytes, odd byte select for odd bytes.
// - With DMA on acknowledge, read acknowledge low is the DMA request.
// - Host I/O reads assert the read strobe so the card drives data.
// - DMA from card to host asserts the read strobe as DMA write strobe.
// - Host I/O writes drive the write strobe low to latch card data.
// - DMA from host to card asserts the write strobe as DMA strobe.
// - DMA cycles assert the acknowledge select together with the data strobes.
// - Last DMA write to host asserts terminal count with its strobe.
module pcs_socket_status
    import pcs_pkg::*;
(
    // Clock and reset.
    input  wire logic         CLK,
    input  wire logic         RESET_N,
    // Card pins, raw levels.
    input  wire logic         BATTERY_DETECT_A,
    input  wire logic         BATTERY_DETECT_B,
    input  wire logic         CARD_PRESENT_1,
    input  wire logic         CARD_PRESENT_2,
    input  wire logic         IO_READ_ACK_N,
    input  wire logic         AUDIO_OTHER_IN,
    // Socket configuration.
    input  wire logic         IO_MODE,
    input  wire logic         RING_ENABLE,
    input  wire logic         DMA_ENABLE,
    input  wire logic         DMA_REQ_ON_ACK,
    // Host cycle requests.
    input  wire logic         HOST_REQ_VALID,
    output logic              HOST_REQ_READY,
    input  wire pcs_kind_t    HOST_REQ_KIND,
    input  wire logic         HOST_REQ_ODD,
    input  wire logic         HOST_REQ_WIDE,
    input  wire logic         HOST_REQ_LAST,
    output logic              HOST_DONE,
    output logic              HOST_DONE_ACKED,
    // Card strobes, active low.
    output logic              EVEN_BYTE_SELECT_N,
    output logic              ODD_BYTE_SELECT_N,
    output logic              IO_READ_STROBE_N,
    output logic              IO_WRITE_STROBE_N,
    output logic              DMA_ACKNOWLEDGE_N,
    output logic              TERMINAL_COUNT_N,
    // Status toward the system.
    output pcs_battery_t      BATTERY_STATE,
    output logic              CARD_INSERTED,
    output logic [1:0]        CARD_PRESENT_STATE,
    output logic              STATUS_CHANGE,
    output logic              CARD_STATUS_EVENT,
    output logic              RING_EVENT,
    output logic              DMA_REQUEST,
    output logic              AUDIO_MIX_OUT
);

    function automatic logic is_dma(input pcs_kind_t k);
        is_dma = (k == PCS_DMA_TO_HOST) || (k == PCS_DMA_TO_CARD);
    endfunction : is_dma
    function automatic logic is_read(input pcs_kind_t k);
        is_read = (k == PCS_IO_READ) || (k == PCS_DMA_TO_HOST);
    endfunction : is_read
    wire  [`PCS_IN_W-1:0] pins;
    logic [`PCS_IN_W-1:0] sync1;
    logic [`PCS_IN_W-1:0] sync2;
    logic [`PCS_IN_W-1:0] sync3;
    logic [`PCS_IN_W-1:0] stable;
    logic [`PCS_IN_W-1:0] stable_q;
    assign pins[`PCS_IN_BAT_A] = BATTERY_DETECT_A;
    assign pins[`PCS_IN_BAT_B] = BATTERY_DETECT_B;
    assign pins[`PCS_IN_PRES1] = CARD_PRESENT_1;
    assign pins[`PCS_IN_PRES2] = CARD_PRESENT_2;
    assign pins[`PCS_IN_RDACK] = IO_READ_ACK_N;
    assign pins[`PCS_IN_AUDIO] = AUDIO_OTHER_IN;
    // A pin level is taken only once the second and third stages agree.
    wire [`PCS_IN_W-1:0] agree       = ~(sync2 ^ sync3);
    wire [`PCS_IN_W-1:0] next_stable = (stable & ~agree) | (sync3 & agree);
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1    <= `PCS_IN_RESET;
            sync2    <= `PCS_IN_RESET;
            sync3    <= `PCS_IN_RESET;
            stable   <= `PCS_IN_RESET;
            stable_q <= `PCS_IN_RESET;
        end else begin
            sync1    <= pins;
            sync2    <= sync1;
            sync3    <= sync2;
            stable   <= next_stable;
            stable_q <= stable;
        end
    end
    wire a_st     = stable[`PCS_IN_BAT_A];
    wire b_st     = stable[`PCS_IN_BAT_B];
    wire p1_st    = stable[`PCS_IN_PRES1];
    wire p2_st    = stable[`PCS_IN_PRES2];
    wire ack_st   = stable[`PCS_IN_RDACK];
    wire audio_st = stable[`PCS_IN_AUDIO];
    wire a_fell   = stable_q[`PCS_IN_BAT_A] & ~a_st;
    wire pcs_battery_t next_battery = !a_st ? PCS_BAT_DEAD :
                                      !b_st ? PCS_BAT_WEAK : PCS_BAT_GOOD;
    wire next_inserted   = !p1_st && !p2_st;
    wire next_change     = |((stable ^ stable_q) & `PCS_STATUS_MASK);
    wire next_card_status_change     = IO_MODE && !RING_ENABLE && a_fell;
    wire next_ring       = IO_MODE && RING_ENABLE && a_fell;
    wire b_is_request    = DMA_ENABLE && !DMA_REQ_ON_ACK;
    wire next_dma_req    = DMA_ENABLE && (DMA_REQ_ON_ACK ? !ack_st : !b_st);
    // The B pin carries speaker only while it is not claimed as DMA request.
    wire speaker         = IO_MODE && !b_is_request && b_st;
    wire next_audio      = speaker ^ audio_st;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            BATTERY_STATE      <= PCS_BAT_GOOD;
            CARD_INSERTED      <= 1'b0;
            CARD_PRESENT_STATE <= 2'h3;
            STATUS_CHANGE      <= 1'b0;
            CARD_STATUS_EVENT  <= 1'b0;
            RING_EVENT         <= 1'b0;
            DMA_REQUEST        <= 1'b0;
            AUDIO_MIX_OUT      <= 1'b0;
        end else begin
            BATTERY_STATE      <= next_battery;
            CARD_INSERTED      <= next_inserted;
            CARD_PRESENT_STATE <= {p2_st, p1_st};
            STATUS_CHANGE      <= next_change;
            CARD_STATUS_EVENT  <= next_card_status_change;
            RING_EVENT         <= next_ring;
            DMA_REQUEST        <= next_dma_req;
            AUDIO_MIX_OUT      <= next_audio;
        end
    end
    // Two-entry request buffer; the strobe engine takes one entry each time it is idle.
    pcs_cmd_t   buf_mem [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] buf_count;
    pcs_state_t state;
    logic [`PCS_CNT_W-1:0] count;
    pcs_cmd_t   cur;
    logic       ack_seen;
    wire pcs_cmd_t cmd_in     = '{HOST_REQ_KIND, HOST_REQ_ODD, HOST_REQ_WIDE, HOST_REQ_LAST};
    wire           push       = HOST_REQ_VALID && HOST_REQ_READY;
    wire           pop        = (state == PCS_IDLE) && (buf_count != 2'h0);
    wire [1:0]     next_count_buf = buf_count + {1'b0, push} - {1'b0, pop};
    always_ff @(posedge CLK) begin
        if (push) begin
            buf_mem[wr_ptr] <= cmd_in;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_ptr         <= 1'b0;
            rd_ptr         <= 1'b0;
            buf_count      <= 2'h0;
            HOST_REQ_READY <= 1'b0;
        end else begin
            wr_ptr         <= wr_ptr ^ push;
            rd_ptr         <= rd_ptr ^ pop;
            buf_count      <= next_count_buf;
            HOST_REQ_READY <= next_count_buf != `PCS_BUF_FULL;
        end
    end

    wire count_zero = count == '0;
    pcs_state_t              next_state;
    logic [`PCS_CNT_W-1:0]   next_count;
    always_comb begin
        next_state = state;
        next_count = count - 1'b1;
        case (state)
            PCS_IDLE: begin
                next_count = `PCS_CNT_W'(`PCS_SETUP_CYC - 1);
                if (pop) begin
                    next_state = PCS_SETUP;
                end
            end
            PCS_SETUP: begin
                if (count_zero) begin
                    next_state = PCS_STROBE;
                    next_count = `PCS_CNT_W'(`PCS_STROBE_CYC - 1);
                end
            end
            PCS_STROBE: begin
                if (count_zero) begin
                    next_state = PCS_HOLD;
                    next_count = `PCS_CNT_W'(`PCS_HOLD_CYC - 1);
                end
            end
            PCS_HOLD: begin
                if (count_zero) begin
                    next_state = PCS_IDLE;
                end
            end
            default: begin
                next_state = PCS_IDLE;
            end
        endcase
    end

    wire pcs_cmd_t sel       = pop ? buf_mem[rd_ptr] : cur;
    wire next_active         = next_state != PCS_IDLE;
    wire next_strobe         = next_state == PCS_STROBE;
    wire next_even_n         = !(next_active && (sel.wide || !sel.odd));
    wire next_odd_n          = !(next_active && (sel.wide || sel.odd));
    wire next_rd_n           = !(next_strobe && is_read(sel.kind));
    wire next_wr_n           = !(next_strobe && !is_read(sel.kind));
    wire next_dma_acknowledge_n         = !(next_active && is_dma(sel.kind));
    wire next_tc_n           = !(next_strobe && sel.kind == PCS_DMA_TO_HOST && sel.last);
    wire finishing           = (state == PCS_HOLD) && count_zero;
    // Acknowledge is only meaningful while a host read strobe is out.
    wire ack_now             = (state == PCS_STROBE) && (cur.kind == PCS_IO_READ) && !ack_st;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= PCS_IDLE;
            count <= '0;
            cur   <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
            cur   <= sel;
        end
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_seen           <= 1'b0;
            HOST_DONE          <= 1'b0;
            HOST_DONE_ACKED    <= 1'b0;
            EVEN_BYTE_SELECT_N <= 1'b1;
            ODD_BYTE_SELECT_N  <= 1'b1;
            IO_READ_STROBE_N   <= 1'b1;
            IO_WRITE_STROBE_N  <= 1'b1;
            DMA_ACKNOWLEDGE_N  <= 1'b1;
            TERMINAL_COUNT_N   <= 1'b1;
        end else begin
            ack_seen           <= !pop && (ack_seen || ack_now);
            HOST_DONE          <= finishing;
            HOST_DONE_ACKED    <= finishing && ack_seen;
            EVEN_BYTE_SELECT_N <= next_even_n;
            ODD_BYTE_SELECT_N  <= next_odd_n;
            IO_READ_STROBE_N   <= next_rd_n;
            IO_WRITE_STROBE_N  <= next_wr_n;
            DMA_ACKNOWLEDGE_N  <= next_dma_acknowledge_n;
            TERMINAL_COUNT_N   <= next_tc_n;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_strobe_start(pcs_kind_t k);
        state == PCS_SETUP && count_zero && cur.kind == k;
    endsequence
    property p_battery_dead;
        !a_st |=> BATTERY_STATE == PCS_BAT_DEAD;
    endproperty
    a_battery_dead: assert property (p_battery_dead) else $error("battery dead not shown");
    property p_battery_weak;
        a_st && !b_st |=> BATTERY_STATE == PCS_BAT_WEAK;
    endproperty
    a_battery_weak: assert property (p_battery_weak) else $error("battery weak not shown");
    property p_status_event;
        IO_MODE && !RING_ENABLE && $fell(a_st) |=> CARD_STATUS_EVENT && !RING_EVENT;
    endproperty
    a_status_event: assert property (p_status_event) else $error("status change event lost");
    property p_ring_event;
        IO_MODE && RING_ENABLE && $fell(a_st) |=> RING_EVENT && !CARD_STATUS_EVENT;
    endproperty
    a_ring_event: assert property (p_ring_event) else $error("ring event lost");
    property p_audio_gate;
        !IO_MODE |=> AUDIO_MIX_OUT == $past(audio_st);
    endproperty
    a_audio_gate: assert property (p_audio_gate) else $error("speaker passed outside I/O mode");
    property p_dma_req_b;
        b_is_request |=> DMA_REQUEST != $past(b_st) && AUDIO_MIX_OUT == $past(audio_st);
    endproperty
    a_dma_req_b: assert property (p_dma_req_b) else $error("DMA request from B wrong");
    property p_dma_req_ack;
        DMA_ENABLE && DMA_REQ_ON_ACK |=> DMA_REQUEST != $past(ack_st);
    endproperty
    a_dma_req_ack: assert property (p_dma_req_ack) else $error("DMA request from ack wrong");
    property p_inserted;
        ##1 CARD_INSERTED == (!$past(p1_st) && !$past(p2_st));
    endproperty
    a_inserted: assert property (p_inserted) else $error("card presence wrong");
    property p_bytes;
        state != PCS_IDLE |-> EVEN_BYTE_SELECT_N == !(cur.wide || !cur.odd)
                           && ODD_BYTE_SELECT_N == !(cur.wide || cur.odd);
    endproperty
    a_bytes: assert property (p_bytes) else $error("byte selects wrong");
    property p_io_read;
        s_strobe_start(PCS_IO_READ) |=> (!IO_READ_STROBE_N && IO_WRITE_STROBE_N)[*8];
    endproperty
    a_io_read: assert property (p_io_read) else $error("I/O read strobe missing");
    property p_dma_to_host;
        s_strobe_start(PCS_DMA_TO_HOST) |=> (!IO_READ_STROBE_N && !DMA_ACKNOWLEDGE_N)[*8];
    endproperty
    a_dma_to_host: assert property (p_dma_to_host) else $error("DMA write strobe missing");
    property p_io_write;
        s_strobe_start(PCS_IO_WRITE) |=> (!IO_WRITE_STROBE_N && DMA_ACKNOWLEDGE_N)[*8];
    endproperty
    a_io_write: assert property (p_io_write) else $error("I/O write strobe missing");
    property p_dma_to_card;
        s_strobe_start(PCS_DMA_TO_CARD) |=> (!IO_WRITE_STROBE_N && IO_READ_STROBE_N)[*8];
    endproperty
    a_dma_to_card: assert property (p_dma_to_card) else $error("DMA read strobe missing");
    property p_dma_acknowledge;
        !(IO_READ_STROBE_N && IO_WRITE_STROBE_N) && is_dma(cur.kind) |-> !DMA_ACKNOWLEDGE_N;
    endproperty
    a_dma_acknowledge: assert property (p_dma_acknowledge) else $error("DMA acknowledge missing");
    property p_tc;
        state == PCS_STROBE |-> TERMINAL_COUNT_N == !(cur.kind == PCS_DMA_TO_HOST && cur.last);
    endproperty
    a_tc: assert property (p_tc) else $error("terminal count wrong");
    property p_change;
        $changed(a_st) || $changed(b_st) || $changed(p1_st) || $changed(p2_st) |=> STATUS_CHANGE;
    endproperty
    a_change: assert property (p_change) else $error("status change not flagged");
    property p_done;
        $rose(state == PCS_SETUP) |-> ##[45:47] HOST_DONE;
    endproperty
    a_done: assert property (p_done) else $error("cycle did not finish in time");

endmodule : pcs_socket_status
`default_nettype wire

// ===== pcs_socket_status_tb.sv
/*
 * Self-checking bench of the socket status and strobe block with a card model.
 * Assumes the design constants header and the type package are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_socket_status_tb
    import pcs_pkg::*;
;
    localparam int SEL = `PCS_SETUP_CYC + `PCS_STROBE_CYC + `PCS_HOLD_CYC;
    localparam int STB = `PCS_STROBE_CYC;
    logic CLK = 1'b0, RESET_N = 1'b0;
    logic bat_a = 1'b1, bat_b = 1'b1, answer = 1'b0, dreq = 1'b0;
    logic [1:0] ins = 2'h0;
    logic IO_MODE = 0, RING_ENABLE = 0, DMA_ENABLE = 0, DMA_REQ_ON_ACK = 0, AUDIO_OTHER_IN = 0;
    logic HOST_REQ_VALID = 0, HOST_REQ_ODD = 0, HOST_REQ_WIDE = 0, HOST_REQ_LAST = 0;
    pcs_kind_t HOST_REQ_KIND = PCS_IO_READ;
    logic BATTERY_DETECT_A, BATTERY_DETECT_B, CARD_PRESENT_1, CARD_PRESENT_2, IO_READ_ACK_N;
    logic HOST_REQ_READY, HOST_DONE, HOST_DONE_ACKED, EVEN_BYTE_SELECT_N, ODD_BYTE_SELECT_N;
    logic IO_READ_STROBE_N, IO_WRITE_STROBE_N, DMA_ACKNOWLEDGE_N, TERMINAL_COUNT_N;
    logic CARD_INSERTED, STATUS_CHANGE, CARD_STATUS_EVENT, RING_EVENT, DMA_REQUEST;
    logic AUDIO_MIX_OUT, saw_full = 1'b0;
    logic [1:0] CARD_PRESENT_STATE;
    pcs_battery_t BATTERY_STATE;
    logic [7:0] n_ev = 0, n_od = 0, n_rd = 0, n_wr = 0, n_dk = 0, n_tc = 0;
    logic [7:0] n_sc = 0, n_cse = 0, n_ring = 0, sc0, cse0, ring0;
    int fail_count = 0, tests_run = 0, seed = 64595, r;
    pcs_cmd_t exp_q[$];

    pcs_socket_status dut (.CLK, .RESET_N, .BATTERY_DETECT_A, .BATTERY_DETECT_B,
        .CARD_PRESENT_1, .CARD_PRESENT_2, .IO_READ_ACK_N, .AUDIO_OTHER_IN, .IO_MODE,
        .RING_ENABLE, .DMA_ENABLE, .DMA_REQ_ON_ACK, .HOST_REQ_VALID, .HOST_REQ_READY,
        .HOST_REQ_KIND, .HOST_REQ_ODD, .HOST_REQ_WIDE, .HOST_REQ_LAST, .HOST_DONE,
        .HOST_DONE_ACKED, .EVEN_BYTE_SELECT_N, .ODD_BYTE_SELECT_N, .IO_READ_STROBE_N,
        .IO_WRITE_STROBE_N, .DMA_ACKNOWLEDGE_N, .TERMINAL_COUNT_N, .BATTERY_STATE,
        .CARD_INSERTED, .CARD_PRESENT_STATE, .STATUS_CHANGE, .CARD_STATUS_EVENT,
        .RING_EVENT, .DMA_REQUEST, .AUDIO_MIX_OUT);
    pcs_card_model card (.clk(CLK), .bat_a, .bat_b, .ins, .answer, .dreq,
        .io_read_strobe_n(IO_READ_STROBE_N), .dma_acknowledge_n(DMA_ACKNOWLEDGE_N),
        .battery_detect_a(BATTERY_DETECT_A), .battery_detect_b(BATTERY_DETECT_B),
        .card_present_1(CARD_PRESENT_1), .card_present_2(CARD_PRESENT_2),
        .io_read_ack_n(IO_READ_ACK_N));

    always #(`PCS_CLK_NS / 2) CLK = ~CLK;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask : tick

    task automatic mark();
        sc0 = n_sc;
        cse0 = n_cse;
        ring0 = n_ring;
    endtask : mark

    // The request is held until the edge that sees ready high takes it.
    task automatic send(input pcs_kind_t k, input logic [2:0] f);
        int w;
        HOST_REQ_VALID <= 1'b1;
        HOST_REQ_KIND <= k;
        {HOST_REQ_ODD, HOST_REQ_WIDE, HOST_REQ_LAST} <= f;
        w = 0;
        do begin
            @(posedge CLK);
            w++;
        end while (HOST_REQ_READY !== 1'b1 && w < 200);
        if (w >= 200) check("ready wait", 8'h1, 8'h0);
        exp_q.push_back('{k, f[2], f[1], f[0]});
    endtask : send

    // Sampling on the falling edge sees every registered output settled.
    always @(negedge CLK) begin
        pcs_cmd_t c;
        if (RESET_N === 1'b1) begin
            if (HOST_REQ_VALID === 1'b1 && HOST_REQ_READY === 1'b0) saw_full = 1'b1;
            n_sc += 8'(STATUS_CHANGE === 1'b1);
            n_cse += 8'(CARD_STATUS_EVENT === 1'b1);
            n_ring += 8'(RING_EVENT === 1'b1);
            if (HOST_DONE === 1'b1) begin
                if (exp_q.size() == 0) begin
                    check("unexpected done", 8'h0, 8'h1);
                end else begin
                    c = exp_q.pop_front();
                    check("even select", 8'((c.wide | ~c.odd) ? SEL : 0), n_ev);
                    check("odd select", 8'((c.wide | c.odd) ? SEL : 0), n_od);
                    check("read strobe", 8'(c.kind[0] ? 0 : STB), n_rd);
                    check("write strobe", 8'(c.kind[0] ? STB : 0), n_wr);
                    check("dma ack", 8'(c.kind[1] ? SEL : 0), n_dk);
                    check("tc", 8'((c.kind == PCS_DMA_TO_HOST && c.last) ? STB : 0), n_tc);
                    check("acked", 8'(c.kind == PCS_IO_READ && answer), 8'(HOST_DONE_ACKED));
                end
                {n_ev, n_od, n_rd, n_wr, n_dk, n_tc} = '0;
            end else begin
                n_ev += 8'(EVEN_BYTE_SELECT_N === 1'b0);
                n_od += 8'(ODD_BYTE_SELECT_N === 1'b0);
                n_rd += 8'(IO_READ_STROBE_N === 1'b0);
                n_wr += 8'(IO_WRITE_STROBE_N === 1'b0);
                n_dk += 8'(DMA_ACKNOWLEDGE_N === 1'b0);
                n_tc += 8'(TERMINAL_COUNT_N === 1'b0);
            end
        end
    end

    initial begin
        logic [1:0] bseq[4];
        logic [1:0] pseq[4];
        int w;
        bseq = '{2'h2, 2'h0, 2'h1, 2'h3};
        pseq = '{2'h1, 2'h3, 2'h2, 2'h0};
        tick(11);
        check("ready in reset", 8'h0, 8'(HOST_REQ_READY));
        check("strobes in reset", 8'h3, 8'({IO_READ_STROBE_N, IO_WRITE_STROBE_N}));
        check("present in reset", 8'h3, 8'(CARD_PRESENT_STATE));
        tick(1);
        RESET_N <= 1'b1;
        tick(4);
        // Outside I/O mode a battery change is status only, never an event.
        for (int i = 0; i < 4; i++) begin
            mark();
            {bat_a, bat_b} <= bseq[i];
            tick(10);
            check("battery", bseq[i][1] ? (bseq[i][0] ? 8'h0 : 8'h1) : 8'h2, 8'(BATTERY_STATE));
            check("status change", sc0 + 8'h1, n_sc);
        end
        check("events off", 8'h0, n_cse + n_ring);
        $display("test battery finished");
        for (int i = 0; i < 4; i++) begin
            mark();
            ins <= pseq[i];
            tick(10);
            check("inserted", 8'(pseq[i] == 2'h3), 8'(CARD_INSERTED));
            check("present state", 8'(pseq[i] ^ 2'h3), 8'(CARD_PRESENT_STATE));
            check("present change", sc0 + 8'h1, n_sc);
        end
        $display("test presence finished");
        IO_MODE <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            mark();
            RING_ENABLE <= i[0];
            bat_a <= 1'b0;
            tick(10);
            bat_a <= 1'b1;
            tick(10);
            check("status event", cse0 + 8'(!i[0]), n_cse);
            check("ring event", ring0 + 8'(i[0]), n_ring);
        end
        $display("test events finished");
        DMA_ENABLE <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            DMA_REQ_ON_ACK <= i[1];
            bat_b <= ~(i[0] & ~i[1]);
            dreq <= i[0] & i[1];
            tick(10);
            check("dma request", 8'(i[0]), 8'(DMA_REQUEST));
        end
        DMA_ENABLE <= 1'b0;
        dreq <= 1'b0;
        $display("test dma request finished");
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            {AUDIO_OTHER_IN, bat_b, IO_MODE} <= r[2:0];
            tick(10);
            check("audio", 8'((r[0] & r[1]) ^ r[2]), 8'(AUDIO_MIX_OUT));
        end
        $display("test audio finished");
        for (int b = 0; b < 3; b++) begin
            answer <= b[0];
            tick(1);
            for (int i = 0; i < 6; i++) begin
                r = $random(seed);
                send(pcs_kind_t'(i[1:0] + b[1:0]), r[2:0]);
            end
            HOST_REQ_VALID <= 1'b0;
            w = 0;
            while (exp_q.size() != 0 && w < 1000) begin
                tick(1);
                w++;
            end
            check("drained", 8'h0, 8'(exp_q.size()));
            tick(3);
        end
        check("buffer refused", 8'h1, 8'(saw_full));
        $display("test host cycles finished");
        tally_and_finish();
    end

    initial begin
        #(10000 * `PCS_CLK_NS);
        fail_count++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule : pcs_socket_status_tb
`default_nettype wire
